/* dpcs_top.v */
/*
 Drive profile control word interpreter. Takes the cyclic control word
 and frequency setpoint from the fieldbus side, runs the S1..S5 profile,
 arbitrates local function-code commands and returns the status word.
 Assumes the fieldbus words arrive on mclk with a one-cycle write strobe,
 and that trip, motor-stopped and auto-tune request come from pins.
*/
`timescale 1ns/1ns
`default_nettype none
`include "dpcs_defs.vh"

module dpcs_top (
   input  wire        mclk,
   input  wire        rstn,
   input  wire        cw_wr,
   input  wire [15:0] drive_control_word,
   input  wire [15:0] frequency_setpoint_word,
   input  wire [15:0] core_out_freq,
   input  wire [15:0] detect_level,
   input  wire        trip_pin,
   input  wire        stopped_pin,
   input  wire        autotune_pin,
   input  wire [15:0] autotune_freq,
   input  wire [15:0] local_run_word,
   input  wire        local_freq_valid,
   input  wire [15:0] local_freq_word,
   output reg  [15:0] drive_status_word,
   output reg  [15:0] output_frequency_word,
   output reg         run_cmd,
   output reg         run_reverse,
   output reg  [15:0] freq_cmd,
   output reg         coast_stop,
   output reg         quick_stop,
   output reg         ramp_hold_zero,
   output reg         ramp_freeze,
   output reg         alarm_reset,
   output reg  [13:0] local_aux_bits,
   output reg  [2:0]  profile_state
);

   // ----------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------
   wire [2:0] pins_s;

   dpcs_sync #(
      .WIDTH    (3)
   ) u_sync (
      .mclk     (mclk),
      .rstn     (rstn),
      .async_in ({autotune_pin, stopped_pin, trip_pin}),
      .sync_out (pins_s)
   );

   wire trip_s     = pins_s[0];
   wire stopped_s  = pins_s[1];
   wire autotune_s = pins_s[2];

   // ----------------------------------------------------------------
   // Word capture
   // ----------------------------------------------------------------
   reg  [15:0] ctw_r;
   reg  [15:0] act_cw_r;
   reg  [15:0] setp_r;
   reg         alm_prev_r;
   reg  [1:0]  rel_prev_r;

   // Raw word is always kept so the status mirror follows the master
   always @(posedge mclk) begin
      if (!rstn) begin
         ctw_r    <= `DPCS_WORD_RST;
         act_cw_r <= `DPCS_WORD_RST;
         setp_r   <= `DPCS_WORD_RST;
      end else if (cw_wr) begin
         ctw_r <= drive_control_word;
         if (drive_control_word[`DPCS_CW_ENA_PCD]) begin // see [RL7]
            act_cw_r <= drive_control_word;
            setp_r   <= frequency_setpoint_word;
         end
      end
   end

   wire cw_run    = act_cw_r[`DPCS_CW_RUN];
   wire cw_coast  = act_cw_r[`DPCS_CW_COAST_N];
   wire cw_qstop  = act_cw_r[`DPCS_CW_QSTOP_N];
   wire cw_enop   = act_cw_r[`DPCS_CW_ENA_OP];
   // Bit 10 taken from the raw word: clearing it must stop running at once
   wire cw_gates  = act_cw_r[`DPCS_CW_ENA_RAMP] & act_cw_r[`DPCS_CW_UNFREEZE] &
                    act_cw_r[`DPCS_CW_ENA_SETP] & ctw_r[`DPCS_CW_ENA_PCD];
   wire cw_alm    = act_cw_r[`DPCS_CW_ALARM_RESET_BIT];
   wire alm_rise  = cw_alm & ~alm_prev_r;
   // Each stop bit has its own edge: a release of one while the other stays set counts
   wire [1:0] rel_now = {cw_qstop, cw_coast};
   wire rel_rise  = |(rel_now & ~rel_prev_r); // see [RL21]

   // ----------------------------------------------------------------
   // Profile state machine
   // ----------------------------------------------------------------
   reg  [2:0] state_r;
   reg  [2:0] state_nxt;
   reg        lock_r;
   reg        lock_nxt;

   always @* begin
      state_nxt = state_r;
      lock_nxt  = lock_r;
      if (rel_rise)
         lock_nxt = 1'b0; // see [RL21]
      case (state_r)
         `DPCS_S1: begin
            if (cw_coast & cw_qstop & ~cw_run & ~cw_alm)
               state_nxt = `DPCS_S2; // see [RL24]
         end
         `DPCS_S2: begin
            if (~cw_coast | ~cw_qstop)
               state_nxt = `DPCS_S1; // see [RL2] [RL3]
            else if (cw_run)
               state_nxt = `DPCS_S3; // see [RL24] [RL17]
         end
         `DPCS_S3: begin
            if (~cw_coast | ~cw_qstop)
               state_nxt = `DPCS_S1;
            else if (~cw_run)
               state_nxt = `DPCS_S2;
            else if (cw_enop)
               state_nxt = `DPCS_S4; // see [RL24] [RL17]
         end
         `DPCS_S4: begin
            if (~cw_coast) begin
               state_nxt = `DPCS_S1; // see [RL2]
               lock_nxt  = 1'b1;     // see [RL21]
            end else if (~cw_run | ~cw_qstop)
               state_nxt = `DPCS_S5; // see [RL18] [RL3]
         end
         `DPCS_S5: begin
            if (~cw_coast) begin
               state_nxt = `DPCS_S1;
               lock_nxt  = 1'b1; // see [RL21]
            end else if (stopped_s) begin
               if (~cw_qstop) begin
                  state_nxt = `DPCS_S1; // see [RL19]
                  lock_nxt  = 1'b1;     // see [RL21]
               end else
                  state_nxt = `DPCS_S2; // see [RL19]
            end
         end
         default: begin
            state_nxt = `DPCS_S1;
         end
      endcase
      // Alarm reset leaves the profile not ready
      if (alm_rise)
         state_nxt = `DPCS_S1; // see [RL6]
   end

   always @(posedge mclk) begin
      if (!rstn) begin
         state_r    <= `DPCS_S1; // see [RL16]
         lock_r     <= 1'b0;
         alm_prev_r <= 1'b0;
         rel_prev_r <= 2'b11;
      end else begin
         state_r    <= state_nxt;
         lock_r     <= lock_nxt;
         alm_prev_r <= cw_alm;
         rel_prev_r <= rel_now;
      end
   end

   // ----------------------------------------------------------------
   // Command arbitration
   // ----------------------------------------------------------------
   wire in_s1      = (state_r == `DPCS_S1);
   wire in_s4      = (state_r == `DPCS_S4);
   wire in_s5      = (state_r == `DPCS_S5);
   wire loc_run_on = in_s1 & (local_run_word[0] | local_run_word[1]); // see [RL20]
   wire loc_frq_on = in_s1 & local_freq_valid;                        // see [RL20]
   // Locked local run still counts as local, held at zero speed
   wire loc_run_ok = loc_run_on & ~lock_r; // see [RL21]
   wire bus_run    = in_s4 & cw_run & cw_gates; // see [RL1] [RL9] [RL17]

   reg  [15:0] tgt_word;
   reg  [15:0] tgt_mag;
   reg         tgt_rev;
   reg         run_nxt;

   always @* begin
      tgt_word = setp_r;
      tgt_rev  = act_cw_r[`DPCS_CW_REVERSE]; // see [RL8]
      run_nxt  = bus_run;
      if (loc_frq_on)
         tgt_word = local_freq_word;
      if (loc_run_on) begin
         run_nxt = loc_run_ok;
         tgt_rev = local_run_word[1];
      end
      if (loc_run_on & lock_r)
         tgt_word = `DPCS_WORD_RST;
      if (autotune_s) begin
         tgt_word = autotune_freq; // see [RL22]
         run_nxt  = 1'b1;          // see [RL22]
      end
      // Two's complement setpoint: negative flips the direction
      if (tgt_word[15]) begin
         tgt_mag = ~tgt_word + 16'h0001; // see [RL23]
         tgt_rev = ~tgt_rev;             // see [RL23]
      end else
         tgt_mag = tgt_word;
   end

   // ----------------------------------------------------------------
   // Frequency monitors
   // ----------------------------------------------------------------
   wire [15:0] out_mag  = core_out_freq[15] ? (~core_out_freq + 16'h0001) :
                          core_out_freq;
   wire        arrived  = run_cmd & (out_mag == freq_cmd);           // see [RL13]
   wire        at_level = (out_mag >= detect_level);                 // see [RL15]
   wire        remote   = ~loc_run_on | ~loc_frq_on;                 // see [RL14]
   wire        rdy_on   = (state_r == `DPCS_S2) | (state_r == `DPCS_S3) | in_s4;
   wire        rdy_run  = (state_r == `DPCS_S3) | in_s4;

   reg  [15:0] sw_nxt;

   always @* begin
      sw_nxt                     = `DPCS_WORD_RST;
      sw_nxt[`DPCS_SW_RDY_ON]    = rdy_on;
      sw_nxt[`DPCS_SW_RDY_RUN]   = rdy_run;
      sw_nxt[`DPCS_SW_RUNNING]   = in_s4 & run_cmd;
      sw_nxt[`DPCS_SW_TRIP]      = trip_s;                   // see [RL11]
      sw_nxt[`DPCS_SW_COAST_N]   = ctw_r[`DPCS_CW_COAST_N];  // see [RL12]
      sw_nxt[`DPCS_SW_QSTOP_N]   = ctw_r[`DPCS_CW_QSTOP_N];  // see [RL12]
      sw_nxt[`DPCS_SW_ON_INHIB]  = ~rdy_on;                  // see [RL10]
      sw_nxt[`DPCS_SW_ARRIVED]   = arrived;
      sw_nxt[`DPCS_SW_REMOTE]    = remote;
      sw_nxt[`DPCS_SW_LEVEL]     = at_level;
   end

   // ----------------------------------------------------------------
   // Registered outputs
   // ----------------------------------------------------------------
   always @(posedge mclk) begin
      if (!rstn) begin
         drive_status_word     <= `DPCS_SW_RST;
         output_frequency_word <= `DPCS_WORD_RST;
         run_cmd               <= 1'b0;
         run_reverse           <= 1'b0;
         freq_cmd              <= `DPCS_WORD_RST;
         coast_stop            <= 1'b1;
         quick_stop            <= 1'b0;
         ramp_hold_zero        <= 1'b1;
         ramp_freeze           <= 1'b0;
         alarm_reset           <= 1'b0;
         local_aux_bits        <= 14'h0000;
         profile_state         <= `DPCS_S1;
      end else begin
         drive_status_word     <= sw_nxt;
         output_frequency_word <= core_out_freq; // see [RL23]
         run_cmd               <= run_nxt;
         run_reverse           <= tgt_rev;
         freq_cmd              <= tgt_mag;
         coast_stop            <= ~cw_coast & ~autotune_s;                  // see [RL2]
         quick_stop            <= ~cw_qstop & (in_s4 | in_s5);              // see [RL3]
         ramp_hold_zero        <= ~act_cw_r[`DPCS_CW_ENA_RAMP] & ~autotune_s; // see [RL4]
         ramp_freeze           <= ~act_cw_r[`DPCS_CW_UNFREEZE] & ~autotune_s; // see [RL5]
         alarm_reset           <= alm_rise;                                 // see [RL6]
         local_aux_bits        <= local_run_word[15:2];                     // see [RL20]
         profile_state         <= state_nxt;
      end
   end

endmodule // dpcs_top

`default_nettype wire

/* dpcs_defs.vh */
/*
 Constants for the drive profile control word interpreter: control and
 status word bit positions, profile state codes and reset values.
 Assumes it is included by bare name from the design files.
*/
// Overview of operation
// [RL1] Control bit 0 switches the run command on when set, off when clear.
// [RL2] Control bit 1 clear coasts to stop; set requests readiness for run.
// [RL3] Control bit 2 clear makes a quick stop; set requests readiness.
// [RL4] Control bit 4 clear holds output at zero; set enables the ramp.
// [RL5] Control bit 5 clear freezes the ramp; set releases the freeze.
// [RL6] Control bit 7 resets an alarm and drops the profile to not ready.
// [RL7] Control bit 10 set enables control and setpoint words; clear ignores them.
// [RL8] Control bit 11 picks run direction: clear forward, set reverse.
// [RL9] No running while control bits 4, 5, 6 or 10 are clear.
// [RL10] Status bit 6 is always the inverse of status bit 0.
// [RL11] Status bit 3 shows the inverter trip condition.
// [RL12] Status bits 4 and 5 mirror control bits 1 and 2.
// [RL13] Status bit 8 is set once output frequency reaches the reference.
// [RL14] Status bit 9 set while fieldbus run or frequency command is in effect.
// [RL15] Status bit 10 set while output frequency is at or above detect level.
// [RL16] After power-on the profile starts in S1, not ready for a run command.
// [RL17] Master steps the profile through S2, S3, S4; drive runs only in S4.
// [RL18] Run command cleared in S4 moves the profile to S5.
// [RL19] In S5 the profile returns to S2 or S1 once the motor has stopped.
// [RL20] Local run and frequency commands act only in S1; aux bits always.
// [RL21] After a stop drops S4/S5 to S1, local run waits for a stop release.
// [RL22] A fieldbus auto-tuning request runs the drive regardless of state; here the request comes from autotune_pin.
// [RL23] Setpoint words scale 4000hex to maximum; negative setpoint reverses.
// [RL24] S1 to S2 on bits 1,2 set, bit 0 clear; S2 to S3 on bit 0; S3 to S4 on bit 3. Code also needs bit 7 clear for S1 to S2.
`ifndef DPCS_DEFS_VH
`define DPCS_DEFS_VH

// Control word bit positions
`define DPCS_CW_RUN        0
`define DPCS_CW_COAST_N    1
`define DPCS_CW_QSTOP_N    2
`define DPCS_CW_ENA_OP     3
`define DPCS_CW_ENA_RAMP   4
`define DPCS_CW_UNFREEZE   5
`define DPCS_CW_ENA_SETP   6
`define DPCS_CW_ALARM_RESET_BIT    7
`define DPCS_CW_ENA_PCD    10
`define DPCS_CW_REVERSE    11

// Status word bit positions
`define DPCS_SW_RDY_ON     0
`define DPCS_SW_RDY_RUN    1
`define DPCS_SW_RUNNING    2
`define DPCS_SW_TRIP       3
`define DPCS_SW_COAST_N    4
`define DPCS_SW_QSTOP_N    5
`define DPCS_SW_ON_INHIB   6
`define DPCS_SW_ARRIVED    8
`define DPCS_SW_REMOTE     9
`define DPCS_SW_LEVEL      10

// Profile states
`define DPCS_S1            3'h1
`define DPCS_S2            3'h2
`define DPCS_S3            3'h3
`define DPCS_S4            3'h4
`define DPCS_S5            3'h5

// Reset values and scaling
`define DPCS_WORD_RST      16'h0000
// Status after reset: not ready, run-on inhibited
`define DPCS_SW_RST        16'h0040
`define DPCS_FULL_SCALE    16'h4000

`endif

/* dpcs_sync.v */
/*
 Two flip-flop synchroniser, one stage pair per bit.
 Assumes the inputs are asynchronous levels from pins of the inverter core.
*/
`timescale 1ns/1ns
`default_nettype none

module dpcs_sync #(
   parameter WIDTH = 3
) (
   input  wire             mclk,
   input  wire             rstn,
   input  wire [WIDTH-1:0] async_in,
   output wire [WIDTH-1:0] sync_out
);

   reg [WIDTH-1:0] meta_r;
   reg [WIDTH-1:0] sync_r;

   genvar i;
   generate
      for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
         always @(posedge mclk) begin
            if (!rstn) begin
               meta_r[i] <= 1'b0;
               sync_r[i] <= 1'b0;
            end else begin
               meta_r[i] <= async_in[i];
               sync_r[i] <= meta_r[i];
            end
         end
      end
   endgenerate

   assign sync_out = sync_r;

endmodule // dpcs_sync

`default_nettype wire

/* dpcs_props.sv */
/*
 Assertion checker for the drive profile interpreter, bound to dpcs_top.
 Assumes one clock mclk and a synchronous active-low rstn.
*/
`timescale 1ns/1ns
`default_nettype none
module dpcs_props (
   input wire logic        mclk,
   input wire logic        rstn,
   input wire logic        cw_wr,
   input wire logic [15:0] drive_control_word,
   input wire logic [15:0] frequency_setpoint_word,
   input wire logic [15:0] core_out_freq,
   input wire logic [15:0] detect_level,
   input wire logic        trip_pin,
   input wire logic [15:0] drive_status_word,
   input wire logic        run_reverse,
   input wire logic        ramp_hold_zero,
   input wire logic        ramp_freeze,
   input wire logic        alarm_reset,
   input wire logic [2:0]  profile_state
);
   // --------------------
   // Properties
   // --------------------
   // Pins cross a two-stage synchroniser, so level checks wait six quiet cycles
   wire logic [15:0] out_mag = core_out_freq[15] ? 16'h0000 - core_out_freq : core_out_freq;
   default clocking @(posedge mclk); endclocking
   default disable iff (!rstn);
   a_inhibit_inverse: assert property (
      drive_status_word[6] == !drive_status_word[0]) else $error("inhibit flag wrong");
   a_stop_mirror: assert property (cw_wr ##1 !cw_wr [*3] |->
      drive_status_word[5:4] == $past(drive_control_word[2:1], 3)) else $error("stop mirror");
   a_ramp_gates: assert property (cw_wr && drive_control_word[10] ##1 !cw_wr [*3] |->
      {ramp_freeze, ramp_hold_zero} == ~$past(drive_control_word[5:4], 3))
      else $error("ramp gates wrong");
   a_run_direction: assert property (cw_wr && drive_control_word[10] ##1 !cw_wr [*3] |->
      profile_state == 3'h1 || run_reverse ==
      ($past(drive_control_word[11], 3) ^ $past(frequency_setpoint_word[15], 3)))
      else $error("direction wrong");
   a_run_off_state: assert property (profile_state == 3'h4 && cw_wr &&
      drive_control_word[11:0] == 12'h47e |-> ##[1:4] profile_state == 3'h5)
      else $error("no run-off state");
   a_start_idle: assert property (disable iff (1'b0)
      $rose(rstn) |-> profile_state == 3'h1) else $error("not idle after reset");
   a_trip_flag: assert property ($stable(trip_pin) [*6] |->
      drive_status_word[3] == trip_pin) else $error("trip flag wrong");
   a_level_flag: assert property (($stable(core_out_freq) && $stable(detect_level)) [*6] |->
      drive_status_word[10] == (out_mag >= detect_level)) else $error("level flag wrong");
   a_alarm_pulse: assert property (alarm_reset |=>
      !alarm_reset ##[0:3] !drive_status_word[0]) else $error("alarm reset wrong");
endmodule // dpcs_props
bind dpcs_top dpcs_props props_u (.mclk, .rstn, .cw_wr, .drive_control_word,
   .frequency_setpoint_word, .core_out_freq, .detect_level, .trip_pin, .drive_status_word,
   .run_reverse, .ramp_hold_zero, .ramp_freeze, .alarm_reset, .profile_state);
`default_nettype wire

/* dpcs_master.sv */
/*
 Behavioural fieldbus master: writes control word and setpoint together.
 Assumes the caller gives the words in profile order.
*/
`timescale 1ns/1ns
`default_nettype none
module dpcs_master (
   input  wire logic        mclk,
   output var  logic        cw_wr,
   output var  logic [15:0] drive_control_word,
   output var  logic [15:0] frequency_setpoint_word
);
   // --------------------
   // Strobe
   // --------------------
   initial begin
      cw_wr = 1'b0;
      drive_control_word = 16'h0000;
      frequency_setpoint_word = 16'h0000;
   end
   // Lines show the inverse between strobes, so a late sample cannot pass
   task automatic send(input logic [15:0] word, input logic [15:0] setp);
      @(posedge mclk);
      cw_wr <= 1'b1;
      drive_control_word <= word;
      frequency_setpoint_word <= setp;
      @(posedge mclk);
      cw_wr <= 1'b0;
      drive_control_word <= ~word;
      frequency_setpoint_word <= ~setp;
   endtask
endmodule // dpcs_master
`default_nettype wire

/* test_drive_profile_control_state.sv */
/*
 Self-checking bench for the drive profile interpreter.
 Assumes dpcs_top, dpcs_master and dpcs_props are compiled first.
*/
`timescale 1ns/1ns
`default_nettype none
module test_drive_profile_control_state;
   logic               mclk, rstn, trip_pin, stopped_pin, local_freq_valid, autotune_pin;
   logic        [15:0] autotune_freq;
   logic        [15:0] core_out_freq, detect_level, local_run_word, local_freq_word, w;
   wire logic          cw_wr, run_cmd, run_reverse, coast_stop, quick_stop;
   wire logic          ramp_hold_zero, ramp_freeze, alarm_reset;
   wire logic   [15:0] drive_control_word, frequency_setpoint_word, freq_cmd;
   wire logic   [15:0] drive_status_word, output_frequency_word;
   wire logic   [13:0] local_aux_bits;
   wire logic   [2:0]  profile_state;
   wire logic   [15:0] st = {13'h0000, profile_state};
   int                 n_errors, n_compared, i;

   dpcs_master m_u (.mclk, .cw_wr, .drive_control_word, .frequency_setpoint_word);
   dpcs_top dut_u (.mclk, .rstn, .cw_wr, .drive_control_word, .frequency_setpoint_word,
      .core_out_freq, .detect_level, .trip_pin, .stopped_pin, .autotune_pin,
      .autotune_freq, .local_run_word, .local_freq_valid, .local_freq_word,
      .drive_status_word, .output_frequency_word, .run_cmd, .run_reverse, .freq_cmd,
      .coast_stop, .quick_stop, .ramp_hold_zero, .ramp_freeze, .alarm_reset,
      .local_aux_bits, .profile_state);

   // --------------------
   // Tasks
   // --------------------
   initial begin
      mclk = 1'b0;
      forever #50 mclk = ~mclk;
   end
   task automatic settle(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask
   task automatic step(input logic [15:0] word, input logic [15:0] setp);
      m_u.send(word, setp);
      settle(4);
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_compared++;
      if (got !== exp) begin
         n_errors++;
         $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
      end
   endtask
   task automatic chk_bit(input logic got, input logic exp);
      chk({15'h0000, got}, {15'h0000, exp});
   endtask
   task automatic complete_run;
      $display("errors %0d, comparisons %0d", n_errors, n_compared);
      if (n_errors == 0 && n_compared > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   // --------------------
   // Sequence
   // --------------------
   initial begin
      rstn = 1'b0;
      trip_pin = 1'b0;
      stopped_pin = 1'b0;
      local_freq_valid = 1'b0;
      core_out_freq = 16'h0000;
      detect_level = 16'h1000;
      local_run_word = 16'h0000;
      local_freq_word = 16'h1000;
      autotune_pin = 1'b0;
      autotune_freq = 16'h0800;
      settle(5);
      chk(drive_status_word, 16'h0040);
      chk(st, 16'h0001);
      @(posedge mclk) rstn <= 1'b1;
      step(16'h0476, 16'h2000);
      chk(st, 16'h0002);
      chk(drive_status_word, 16'h0231);
      step(16'h0477, 16'h2000);
      chk(st, 16'h0003);
      step(16'h047f, 16'h2000);
      chk(st, 16'h0004);
      chk_bit(run_cmd, 1'b1);
      @(posedge mclk) core_out_freq <= 16'h2000;
      settle(5);
      chk(drive_status_word, 16'h0737);
      chk(output_frequency_word, 16'h2000);
      for (i = 0; i < 4; i++) begin
         step({4'h0, i[1], 11'h47f}, i[0] ? 16'he000 : 16'h2000);
         chk_bit(run_reverse, i[1] ^ i[0]);
         chk(freq_cmd, 16'h2000);
      end
      // Each gate bit cleared alone must stop the run, then restore it
      for (i = 4; i < 8; i++) begin
         w = 16'h047f & ~(16'h0001 << (i == 7 ? 10 : i));
         step(w, 16'h2000);
         chk_bit(run_cmd, 1'b0);
         chk({14'h0000, ramp_freeze, ramp_hold_zero}, {14'h0000, ~w[5:4]});
         step(16'h047f, 16'h2000);
         chk_bit(run_cmd, 1'b1);
      end
      step(16'h047e, 16'h2000);
      chk(st, 16'h0005);
      chk_bit(run_cmd, 1'b0);
      @(posedge mclk) stopped_pin <= 1'b1;
      settle(6);
      chk(st, 16'h0002);
      @(posedge mclk) stopped_pin <= 1'b0;
      step(16'h0477, 16'h2000);
      step(16'h047f, 16'h2000);
      step(16'h047b, 16'h2000);
      chk(st, 16'h0005);
      chk_bit(quick_stop, 1'b1);
      @(posedge mclk) stopped_pin <= 1'b1;
      settle(6);
      chk(st, 16'h0001);
      @(posedge mclk) begin
         stopped_pin <= 1'b0;
         local_run_word <= 16'habc5;
         local_freq_valid <= 1'b1;
      end
      settle(4);
      chk({2'h0, local_aux_bits}, 16'h2af1);
      chk(freq_cmd, 16'h0000);
      chk_bit(drive_status_word[9], 1'b0);
      // Quick-stop release alone, coast bit cleared meanwhile, must free the local run
      step(16'h0475, 16'h2000);
      chk_bit(coast_stop, 1'b1);
      chk(freq_cmd, 16'h1000);
      step(16'h0477, 16'h2000);
      chk(freq_cmd, 16'h1000);
      chk_bit(run_cmd, 1'b1);
      step(16'h0476, 16'h2000);
      chk(st, 16'h0002);
      chk(freq_cmd, 16'h2000);
      m_u.send(16'h04f6, 16'h2000);
      for (i = 0; i < 8 && alarm_reset !== 1'b1; i++)
         settle(1);
      chk_bit(alarm_reset, 1'b1);
      settle(4);
      chk(st, 16'h0001);
      @(posedge mclk) trip_pin <= 1'b1;
      settle(6);
      chk_bit(drive_status_word[3], 1'b1);
      for (i = 0; i < 3; i++) begin
         w = i == 0 ? 16'h0fff : (i == 1 ? 16'h1000 : 16'hf000);
         @(posedge mclk) core_out_freq <= w;
         settle(6);
         chk_bit(drive_status_word[10], i != 0);
      end
      // Auto-tune runs the drive in S1 with no local or fieldbus run present
      @(posedge mclk) begin
         autotune_pin <= 1'b1;
         local_run_word <= 16'h0000;
      end
      settle(5);
      chk_bit(run_cmd, 1'b1);
      chk(freq_cmd, 16'h0800);
      @(posedge mclk) autotune_pin <= 1'b0;
      settle(5);
      chk_bit(run_cmd, 1'b0);
      chk(freq_cmd, 16'h1000);
      complete_run;
   end
endmodule // test_drive_profile_control_state
`default_nettype wire
